// >>> pgpio_ctrl.sv
// Port control registers for three open-drain pins of a power-management device.
// Assumes an I2C slave outside decodes transfers into reg_addr/wr_en/wr_data/rd_en strobes.
//
// Contract
// [R1] Register at 0x1b holds port A/B controls, all eight bits read/write.
// [R2] Register at 0x1c holds port C and misc bits; bit 3 unused.
// [R3] Direction bits: cleared input, set output; B bit7, A bit6, C bit7.
// [R4] Output level bits for ports B and A: bit5 and bit4, low or high.
// [R5] Polarity bits: cleared rising/low, set falling/high; B bit3, A bit2.
// [R6] Bit1 lets port A control standby; bit0 lets port A switch buck A.
// [R7] Bit6 of 0x1c sets port C output level when it is an output.
// [R8] Bit5 of 0x1c switches the auxiliary regulator on or off.
// [R9] Bit4 of 0x1c selects charge voltage 4.20 V or 4.36 V.
// [R10] Bits 2 and 1 let port B and A edges pull interrupt low.
// [R11] Bit0 of 0x1c lets port B switch buck B on or off.
// [R12] Host enables only one of interrupt, buck enable, standby on port A.
// [R13] Buck enabled only if register and pin both enable; likewise standby.
// [R14] Output driven high releases the open-drain pin.
// [R15] Enabled edge on interrupt input pulses interrupt output low then high.
// [R16] Inputs synchronised before detection; registers reset to cleared defaults.
`timescale 1ns/1ns
module pgpio_ctrl
	import pgpio_pkg::*;
#(
	parameter int IRQ_WIDTH = PGPIO_IRQ_PULSE_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic port_a_in,
	output logic port_a_out,
	output logic port_a_oe,
	input wire logic port_b_in,
	output logic port_b_out,
	output logic port_b_oe,
	input wire logic port_c_in,
	output logic port_c_out,
	output logic port_c_oe,
	output logic port_c_level,
	output logic port_c_rise,
	output logic port_c_fall,
	input wire logic buck_a_reg_en,
	input wire logic buck_b_reg_en,
	input wire logic standby_reg_req,
	output logic buck_a_en,
	output logic buck_b_en,
	output logic buck_a_standby,
	output logic buck_b_standby,
	output logic aux_regulator_on,
	output logic charge_voltage_select,
	output logic host_irq_n
);
	logic [7:0] pair_reg;
	logic [7:0] third_reg;
	logic a_lvl;
	logic a_rise;
	logic a_fall;
	logic b_lvl;
	logic b_rise;
	logic b_fall;
	logic a_edge;
	logic b_edge;
	logic a_active;
	logic b_active;
	logic irq_trig;

	// Active pin level: polarity set means high level counts, cleared means low
	function automatic logic pin_active(input logic lvl, input logic pol);
		pin_active = pol ? lvl : ~lvl;
	endfunction : pin_active

	// Selected edge: polarity cleared means rising, set means falling
	function automatic logic pin_edge(input logic r, input logic f, input logic pol);
		pin_edge = pol ? f : r;
	endfunction : pin_edge

	// Register writes; power-up values are all cleared
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pair_reg <= PGPIO_PAIR_RESET; // [R16]
			third_reg <= PGPIO_THIRD_RESET; // [R16]
		end
		else if (wr_en)
		begin
			if (reg_addr == PGPIO_PAIR_ADDR)
				pair_reg <= wr_data; // [R1]
			else if (reg_addr == PGPIO_THIRD_ADDR)
				third_reg <= wr_data; // [R2]
		end
	end

	// Reads return stored bits one cycle later; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_en;
			if (rd_en)
			begin
				if (reg_addr == PGPIO_PAIR_ADDR)
					rd_data <= pair_reg; // [R1]
				else if (reg_addr == PGPIO_THIRD_ADDR)
					rd_data <= third_reg; // [R2]
				else
					rd_data <= 8'h00;
			end
		end
	end

	// Input conditioning for each pin
	pgpio_sync u_sync_a (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_a_in),
		.level(a_lvl),
		.rise(a_rise),
		.fall(a_fall)
	); // [R16]

	pgpio_sync u_sync_b (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_b_in),
		.level(b_lvl),
		.rise(b_rise),
		.fall(b_fall)
	); // [R16]

	pgpio_sync u_sync_c (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_c_in),
		.level(port_c_level),
		.rise(port_c_rise),
		.fall(port_c_fall)
	);

	// Open drain: only a low level is driven, a high level releases the pin
	assign port_a_out = 1'b0;
	assign port_b_out = 1'b0;
	assign port_c_out = 1'b0;
	assign port_a_oe = pair_reg[PGPIO_A_DIR] & ~pair_reg[PGPIO_A_OUT]; // [R3] [R4] [R14]
	assign port_b_oe = pair_reg[PGPIO_B_DIR] & ~pair_reg[PGPIO_B_OUT]; // [R3] [R4] [R14]
	assign port_c_oe = third_reg[PGPIO_C_DIR] & ~third_reg[PGPIO_C_OUT]; // [R3] [R7] [R14]

	// Pin commands only count while the pin is an input
	assign a_active = ~pair_reg[PGPIO_A_DIR] & pin_active(a_lvl, pair_reg[PGPIO_A_POL]); // [R5]
	assign b_active = ~pair_reg[PGPIO_B_DIR] & pin_active(b_lvl, pair_reg[PGPIO_B_POL]); // [R5]

	// Both register and pin must agree; a pin not given control never blocks
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			buck_a_en <= 1'b0;
			buck_b_en <= 1'b0;
			buck_a_standby <= 1'b0;
			buck_b_standby <= 1'b0;
		end
		else
		begin
			buck_a_en <= buck_a_reg_en & (~pair_reg[PGPIO_A_BUCKA] | a_active); // [R6] [R13]
			buck_b_en <= buck_b_reg_en & (~third_reg[PGPIO_B_BUCKB] | b_active); // [R11] [R13]
			buck_a_standby <= standby_reg_req & (~pair_reg[PGPIO_A_SBY] | a_active); // [R6] [R13]
			buck_b_standby <= standby_reg_req & (~pair_reg[PGPIO_A_SBY] | a_active); // [R6] [R13]
		end
	end

	// Miscellaneous control levels
	assign aux_regulator_on = third_reg[PGPIO_AUX_ON]; // [R8]
	assign charge_voltage_select = third_reg[PGPIO_CHG_SEL]; // [R9]

	// Interrupt edges: pin must be an input with its interrupt enabled
	assign a_edge = third_reg[PGPIO_A_IRQ] & ~pair_reg[PGPIO_A_DIR]
		& pin_edge(a_rise, a_fall, pair_reg[PGPIO_A_POL]); // [R10]
	assign b_edge = third_reg[PGPIO_B_IRQ] & ~pair_reg[PGPIO_B_DIR]
		& pin_edge(b_rise, b_fall, pair_reg[PGPIO_B_POL]); // [R10]
	assign irq_trig = a_edge | b_edge;

	// Fixed-width low pulse so the host sees a clean high-low-high
	pgpio_pulse #(
		.WIDTH(IRQ_WIDTH)
	) u_pulse (
		.clk(clk),
		.rst_n(rst_n),
		.trig(irq_trig),
		.out_n(host_irq_n)
	); // [R15]
endmodule : pgpio_ctrl

// >>> pgpio_ctrl_checker.sv
// Concurrent checks on the port control block's top ports.
// Assumes a bind to pgpio_ctrl with IRQ_WIDTH handed on.
`timescale 1ns/1ns
module pgpio_ctrl_checker
	import pgpio_pkg::*;
#(
	parameter int IRQ_WIDTH = PGPIO_IRQ_PULSE_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic port_a_out,
	input wire logic port_a_oe,
	input wire logic port_c_level,
	input wire logic port_c_rise,
	input wire logic port_c_fall,
	input wire logic buck_a_reg_en,
	input wire logic buck_a_en,
	input wire logic aux_regulator_on,
	input wire logic charge_voltage_select,
	input wire logic host_irq_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int low_cnt;
	// Length of the running interrupt pulse; a restart only lengthens it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			low_cnt <= 0;
		else
			low_cnt <= host_irq_n ? 0 : low_cnt + 1;
	end
	// Written bits land on the outputs one edge later; past values avoid property-local variables
	rd_answer_a: assert property (rd_en |=> rd_valid)
		else $error("read gave no valid");
	rd_unmapped_a: assert property (rd_en && reg_addr != PGPIO_PAIR_ADDR && reg_addr != PGPIO_THIRD_ADDR
		|=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	aux_write_a: assert property (wr_en && reg_addr == PGPIO_THIRD_ADDR
		|=> aux_regulator_on == $past(wr_data[PGPIO_AUX_ON]))
		else $error("aux output wrong");
	chg_write_a: assert property (wr_en && reg_addr == PGPIO_THIRD_ADDR
		|=> charge_voltage_select == $past(wr_data[PGPIO_CHG_SEL]))
		else $error("charge select wrong");
	pair_oe_a: assert property (wr_en && reg_addr == PGPIO_PAIR_ADDR
		|=> port_a_oe == ($past(wr_data[PGPIO_A_DIR]) & ~$past(wr_data[PGPIO_A_OUT])))
		else $error("port a enable wrong");
	out_zero_a: assert property (wr_en && reg_addr == PGPIO_PAIR_ADDR && wr_data[PGPIO_A_DIR]
		&& wr_data[PGPIO_A_OUT] |=> !port_a_oe && port_a_out == 1'b0)
		else $error("port a high not released");
	c_rise_a: assert property (port_c_rise |-> port_c_level && !$past(port_c_level))
		else $error("port c rise pulse wrong");
	c_fall_a: assert property (port_c_fall |-> !port_c_level && $past(port_c_level))
		else $error("port c fall pulse wrong");
	buck_gate_a: assert property (!buck_a_reg_en |=> !buck_a_en)
		else $error("buck on without command");
	irq_width_a: assert property ($rose(host_irq_n) |-> low_cnt >= IRQ_WIDTH)
		else $error("interrupt pulse short");
	cover property (rd_valid);
	cover property ($fell(host_irq_n));
	cover property (aux_regulator_on);
	cover property (buck_a_en);
endmodule : pgpio_ctrl_checker

// >>> pgpio_ctrl_test.sv
// Bench for the port control registers: access, pins, interrupt, converters.
// Assumes a shortened interrupt pulse; converter commands come from the bench.
`timescale 1ns/1ns
module pgpio_ctrl_test;
	import pgpio_pkg::*;
	localparam int W = 4;
	logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, bb_en = 0, sby = 0, ba_en = 0;
	logic [7:0] reg_addr = 8'h00, wr_data = 8'h00;
	logic [2:0] ext_drv = 3'h7;
	wire [2:0] pin, oe;
	logic [7:0] rd_data;
	logic rd_valid, bb, sa, sb, aux, chg, irq_n, ba, cl;
	int bad_count = 0, checks_done = 0, cyc = 0, n;
	pgpio_ctrl #(.IRQ_WIDTH(W)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .port_a_in(pin[0]),
		.port_a_out(), .port_a_oe(oe[0]), .port_b_in(pin[1]), .port_b_out(), .port_b_oe(oe[1]),
		.port_c_in(pin[2]), .port_c_out(), .port_c_oe(oe[2]), .port_c_level(cl), .port_c_rise(),
		.port_c_fall(), .buck_a_reg_en(ba_en), .buck_b_reg_en(bb_en), .standby_reg_req(sby),
		.buck_a_en(ba), .buck_b_en(bb), .buck_a_standby(sa), .buck_b_standby(sb),
		.aux_regulator_on(aux), .charge_voltage_select(chg), .host_irq_n(irq_n));
	pgpio_pins far (.dev_oe(oe), .ext_drv(ext_drv), .pin(pin));
	always #4 clk = ~clk;
	// Hang guard, well above the run's length
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic ck(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : ck
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		ck("rd_valid", 8'h01, {7'h00, rd_valid});
		ck("rd_data", exp, rd_data);
	endtask : rd
	// Sets the outside drivers, then lets k edges pass
	task automatic pins(logic [2:0] d, int k);
		@(posedge clk);
		ext_drv <= d;
		repeat (k) @(posedge clk);
		#1;
	endtask : pins
	// Waits a bounded time while the interrupt line holds level v
	task automatic hold(logic v, int lim);
		n = 0;
		while (irq_n === v && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : hold
	task automatic t_reset;
		rd(PGPIO_PAIR_ADDR, 8'h00);
		rd(PGPIO_THIRD_ADDR, 8'h00);
		rd(8'h1d, 8'h00);
		ck("oe", 8'h00, {5'h00, oe});
		ck("irq idle", 8'h01, {7'h00, irq_n});
		ck("bucks", 8'h00, {4'h0, ba, bb, sa, sb});
	endtask : t_reset
	// Field decode, stray write, output high releases the wire
	task automatic t_regs;
		wr(PGPIO_PAIR_ADDR, 8'hd0);
		wr(PGPIO_THIRD_ADDR, 8'hbd);
		wr(8'h1a, 8'hff);
		rd(PGPIO_PAIR_ADDR, 8'hd0);
		rd(PGPIO_THIRD_ADDR, 8'hbd);
		ck("oe", 8'h06, {5'h00, oe});
		ck("port c", 8'h00, {7'h00, cl});
		ck("aux chg", 8'h03, {6'h00, aux, chg});
		wr(PGPIO_THIRD_ADDR, 8'hc8);
		rd(PGPIO_THIRD_ADDR, 8'hc8);
		ck("oe", 8'h02, {5'h00, oe});
		ck("port c", 8'h01, {7'h00, cl});
		ck("aux chg", 8'h00, {6'h00, aux, chg});
	endtask : t_regs
	// Port B falling edge pulses the interrupt; rise and cleared enable stay quiet
	task automatic t_irq;
		wr(PGPIO_PAIR_ADDR, 8'h08);
		wr(PGPIO_THIRD_ADDR, 8'h04);
		pins(3'h5, 0);
		hold(1'b1, 10);
		ck("irq", 8'h00, {7'h00, irq_n});
		hold(1'b0, 20);
		ck("irq width", 8'(W), n[7:0]);
		pins(3'h7, 8);
		ck("irq", 8'h01, {7'h00, irq_n});
		wr(PGPIO_THIRD_ADDR, 8'h00);
		pins(3'h5, 8);
		ck("irq", 8'h01, {7'h00, irq_n});
		// Port A with cleared polarity: only a rising edge interrupts
		wr(PGPIO_THIRD_ADDR, 8'h02);
		pins(3'h4, 8);
		ck("irq a fall", 8'h01, {7'h00, irq_n});
		pins(3'h5, 0);
		hold(1'b1, 10);
		ck("irq a", 8'h00, {7'h00, irq_n});
		hold(1'b0, 20);
		ck("irq a width", 8'(W), n[7:0]);
	endtask : t_irq
	// Converters follow register and pin commands together
	task automatic t_buck;
		wr(PGPIO_THIRD_ADDR, 8'h01);
		@(posedge clk) bb_en <= 1'b1;
		pins(3'h7, 6);
		ck("buck b", 8'h01, {7'h00, bb});
		pins(3'h5, 6);
		ck("buck b", 8'h00, {7'h00, bb});
		wr(PGPIO_PAIR_ADDR, 8'h06);
		wr(PGPIO_THIRD_ADDR, 8'h00);
		@(posedge clk) sby <= 1'b1;
		pins(3'h7, 6);
		ck("standby buck b", 8'h07, {5'h00, sa, sb, bb});
		pins(3'h6, 6);
		ck("standby buck b", 8'h01, {5'h00, sa, sb, bb});
	endtask : t_buck
	// Buck A follows port A at low level, and never runs without its register command
	task automatic t_buck_a;
		wr(PGPIO_PAIR_ADDR, 8'h01);
		@(posedge clk) ba_en <= 1'b1;
		pins(3'h6, 6);
		ck("buck a", 8'h01, {7'h00, ba});
		pins(3'h7, 6);
		ck("buck a", 8'h00, {7'h00, ba});
		@(posedge clk) ba_en <= 1'b0;
		pins(3'h6, 6);
		ck("buck a", 8'h00, {7'h00, ba});
	endtask : t_buck_a
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_irq();
		t_buck();
		t_buck_a();
		complete_run();
	end
endmodule : pgpio_ctrl_test
bind pgpio_ctrl pgpio_ctrl_checker #(.IRQ_WIDTH(IRQ_WIDTH)) chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
	.rd_valid(rd_valid), .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_c_level(port_c_level),
	.port_c_rise(port_c_rise), .port_c_fall(port_c_fall), .buck_a_reg_en(buck_a_reg_en),
	.buck_a_en(buck_a_en), .aux_regulator_on(aux_regulator_on),
	.charge_voltage_select(charge_voltage_select), .host_irq_n(host_irq_n));

// >>> pgpio_pins.sv
// Far-side pin model: outside open-drain drivers on pulled-up wires.
// Assumes the bench sets the driver levels; a released wire reads high.
`timescale 1ns/1ns
module pgpio_pins
(
	input wire logic [2:0] dev_oe,
	input wire logic [2:0] ext_drv,
	output logic [2:0] pin
);
	// Either side pulling low wins, else the pull-up holds the wire high
	assign pin = ~dev_oe & ext_drv;
endmodule : pgpio_pins

// >>> pgpio_pkg.sv
// Package for the port control register block: offsets, field positions, defaults, timing.
// Assumes an I2C front end outside that delivers decoded register writes and reads.
package pgpio_pkg;
	localparam logic [7:0] PGPIO_PAIR_ADDR = 8'h1b;
	localparam logic [7:0] PGPIO_THIRD_ADDR = 8'h1c;
	localparam logic [7:0] PGPIO_PAIR_RESET = 8'h00;
	localparam logic [7:0] PGPIO_THIRD_RESET = 8'h00;
	// Fields of pin_pair_control
	localparam int PGPIO_B_DIR = 7;
	localparam int PGPIO_A_DIR = 6;
	localparam int PGPIO_B_OUT = 5;
	localparam int PGPIO_A_OUT = 4;
	localparam int PGPIO_B_POL = 3;
	localparam int PGPIO_A_POL = 2;
	localparam int PGPIO_A_SBY = 1;
	localparam int PGPIO_A_BUCKA = 0;
	// Fields of third_pin_misc_control
	localparam int PGPIO_C_DIR = 7;
	localparam int PGPIO_C_OUT = 6;
	localparam int PGPIO_AUX_ON = 5;
	localparam int PGPIO_CHG_SEL = 4;
	localparam int PGPIO_UNUSED = 3;
	localparam int PGPIO_B_IRQ = 2;
	localparam int PGPIO_A_IRQ = 1;
	localparam int PGPIO_B_BUCKB = 0;
	// Width of the low pulse on the host interrupt output
	localparam int PGPIO_IRQ_PULSE_NS = 1000;
	localparam int PGPIO_CLK_NS = 8;
	localparam int PGPIO_IRQ_PULSE_CYC = (PGPIO_IRQ_PULSE_NS + PGPIO_CLK_NS - 1) / PGPIO_CLK_NS;
endpackage : pgpio_pkg

// >>> pgpio_pulse.sv
// Stretches a one-cycle request into a fixed-width active-low pulse.
// Assumes requests arriving during a pulse may merge into it.
`timescale 1ns/1ns
module pgpio_pulse
	import pgpio_pkg::*;
#(
	parameter int WIDTH = PGPIO_IRQ_PULSE_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig,
	output logic out_n
);
	logic [15:0] cnt_reg;

	// Restart on every trigger so a late edge is never lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= 16'h0000;
		else if (trig)
			cnt_reg <= 16'(WIDTH);
		else if (cnt_reg != 16'h0000)
			cnt_reg <= cnt_reg - 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_n <= 1'b1;
		else
			out_n <= ~(trig | (cnt_reg > 16'h0001));
	end
endmodule : pgpio_pulse

// >>> pgpio_sync.sv
// Two-flop synchroniser with edge detection on the settled level.
// Assumes the pin is driven by an external party at any time.
`timescale 1ns/1ns
module pgpio_sync
	import pgpio_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// First flop is read only by the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;
endmodule : pgpio_sync
